/* File: src/vod_pkg.sv */
// shared constants, types and helpers of the valve output driver
package vod_pkg;

  // ----------------------------------------------------------------
  // sizes and timing
  // ----------------------------------------------------------------
  localparam int NOUT = 10;
  localparam int NGRP = 3;
  localparam int CLK_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / CLK_NS;
  localparam int PWM_HZ = 25000;
  localparam int PWM_NS = 1000000000 / PWM_HZ;
  localparam logic [15:0] PER_25K = 16'(PWM_NS / CLK_NS);

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] OUT_BASE = 12'h100;
  localparam int OUT_SH = 5;
  localparam logic [2:0] W_CFG = 3'h0;
  localparam logic [2:0] W_XRNG = 3'h1;
  localparam logic [2:0] W_YRNG = 3'h2;
  localparam logic [2:0] W_CMD = 3'h3;
  localparam logic [2:0] W_HOT = 3'h4;
  localparam logic [2:0] W_TIM = 3'h5;
  localparam logic [2:0] W_RMP = 3'h6;
  localparam logic [2:0] W_AMP = 3'h7;
  localparam int CFG_RSP_LSB = 4;
  localparam int CFG_EDG = 8;
  localparam int CFG_DLY_LSB = 16;

  // ----------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------
  localparam logic [23:0] DITH_RST = 24'h0186a0;
  localparam logic [15:0] CUR_MAX = 16'h09c4;
  localparam logic [15:0] DUTY_MAX = 16'h03e8;
  localparam logic [15:0] VOLT_MAX = 16'hffff;
  localparam logic [15:0] VOLT_RST = 16'h2ee0;
  localparam logic [15:0] X_MAX_RST = 16'h03e8;
  localparam logic [15:0] AMP_RST = 16'h0064;
  localparam logic [15:0] PUL_RST = 16'h07d0;
  localparam logic [15:0] HLD_RST = 16'h01f4;
  localparam logic [15:0] PMS_RST = 16'h0064;
  localparam logic [15:0] BMS_RST = 16'h01f4;

  typedef enum logic [2:0] {
    VT_OFF = 3'b000, VT_CUR = 3'b001, VT_HOT = 3'b010,
    VT_DUTY = 3'b011, VT_VOLT = 3'b100, VT_ONOFF = 3'b101
  } vod_typ_t;

  typedef enum logic [1:0] {
    RSP_NORM = 2'b00, RSP_INV = 2'b01,
    RSP_LATCH = 2'b10, RSP_BLINK = 2'b11
  } vod_rsp_t;

  typedef struct packed {
    vod_typ_t typ;
    vod_rsp_t rsp;
    logic edg;
    logic [15:0] dly, xmn, xmx, ymn, ymx, x;
    logic [15:0] pul, hld, pms, bms, rup, rdn, amp;
  } vod_cfg_t;

  function automatic logic vod_is_dig(vod_typ_t t);
    return t == VT_HOT || t == VT_ONOFF;
  endfunction : vod_is_dig

  function automatic logic [15:0] vod_lim(vod_typ_t t);
    case (t)
      VT_CUR, VT_HOT: return CUR_MAX;
      VT_DUTY: return DUTY_MAX;
      VT_VOLT: return VOLT_MAX;
      default: return 16'h0001;
    endcase
  endfunction : vod_lim

  function automatic vod_cfg_t vod_dflt(vod_typ_t t);
    vod_cfg_t c;
    c = '0;
    c.typ = t;
    c.xmx = X_MAX_RST;
    c.ymx = (t == VT_VOLT) ? VOLT_RST : vod_lim(t);
    c.pul = PUL_RST;
    c.hld = HLD_RST;
    c.pms = PMS_RST;
    c.bms = BMS_RST;
    c.amp = AMP_RST;
    return c;
  endfunction : vod_dflt

endpackage : vod_pkg

/* File: src/vod_top.sv */
// valve output driver: ten half-bridge outputs behind an ahb-lite slave
`timescale 1ns/100ps
`default_nettype none

// Function
// - ten outputs in groups 1-4, 5-8, 9-10, each group one frequency.
// - type codes 0 off, 1 current, 2 pull-in/hold, 3 duty, 4 volt, 5 on/off.
// - a changed type reloads that output's other settings to type defaults.
// - current type switches at 25 kHz with a dither of set amplitude.
// - dither frequency is one value per group, generated exactly.
// - voltage type scales duty by measured supply to hit target voltage.
// - duty type runs at group frequency, duty 0 to 100 percent.
// - group frequency writes accepted only without current or pull-in outputs.
// - a current or pull-in output forces its group to 25 kHz.
// - on/off type drives fully on while its digital response is on.
// - response codes 0 normal, 1 inverse, 2 latched, 3 blink; digital only.
// - normal follows the command; inverse is on except while commanded on.
// - normal response delays changes by set milliseconds; zero means none.
// - delay edge 0 delays off-to-on only, 1 delays on-to-off only.
// - latched response toggles on each off-to-on command edge.
// - blink toggles at blink rate while commanded on, else stays off.
// - blink response allowed only with on/off type.
// - pull-in/hold drives pull-in current for pull-in time, then hold.
// - output min and max values limited to the type's range.
// - target is linear map y = m*x + a between the axis end points.
// - input axis needs min below max; output axis may be inverted.
// - ramps step output toward target by range over ramp time.
module vod_top #(
  parameter int MS_CYCLES = vod_pkg::MS_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [15:0] vsupply_mv,
  output logic [vod_pkg::NOUT-1:0] hs_on,
  output logic [vod_pkg::NOUT-1:0] ls_on
);
  import vod_pkg::*;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  function automatic int grp(int i);
    return (i < 4) ? 0 : ((i < 8) ? 1 : 2);
  endfunction : grp

  // zero divisor saturates rather than faulting
  function automatic logic [31:0] udiv(logic [31:0] n, logic [15:0] d);
    return (d == 16'h0) ? 32'hffffffff : n / {16'h0, d};
  endfunction : udiv

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic take, wr_r, rd_r;
  logic [11:0] a_r;
  logic [31:0] rdat;
  assign take = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      a_r <= 12'h0;
    end else begin
      wr_r <= take && hwrite;
      rd_r <= take && !hwrite;
      if (take) begin
        a_r <= haddr[11:0];
      end
    end
  end

  // one wait state on reads so a write just before is seen
  assign hreadyout = !rd_r;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (rd_r) begin
      hrdata <= rdat;
    end
  end

  a_rd_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read not answered after one wait state");

  logic [11:0] ofs;
  logic [3:0] oi;
  logic [1:0] gi;
  logic [2:0] wi;
  logic is_out, is_grp;
  always_comb begin
    ofs = a_r - OUT_BASE;
    oi = ofs[8:5];
    wi = a_r[4:2];
    gi = a_r[5:4];
    is_out = a_r >= OUT_BASE && ofs[11:9] == 3'h0 && oi < 4'(NOUT);
    is_grp = a_r[11:6] == 6'h0 && a_r[3] == 1'b0 && gi < 2'(NGRP);
  end

  // ----------------------------------------------------------------
  // per-output configuration
  // ----------------------------------------------------------------
  vod_cfg_t cfg_r [NOUT];
  vod_cfg_t wcfg;
  vod_typ_t nt;
  vod_rsp_t nr;
  logic [3:0] oi_s;
  logic [15:0] lim;

  always_comb begin
    oi_s = is_out ? oi : 4'h0;
    wcfg = cfg_r[oi_s];
    lim = vod_lim(wcfg.typ);
    nt = (hwdata[2:0] > 3'h5) ? VT_OFF : vod_typ_t'(hwdata[2:0]);
    nr = vod_rsp_t'(hwdata[CFG_RSP_LSB+:2]);
    case (wi)
      W_CFG: begin
        if (nt != wcfg.typ) begin
          wcfg = vod_dflt(nt);
        end
        wcfg.rsp = vod_is_dig(nt) ? nr : RSP_NORM;
        if (nr == RSP_BLINK && nt != VT_ONOFF) begin
          wcfg.rsp = RSP_NORM;
        end
        wcfg.edg = hwdata[CFG_EDG];
        wcfg.dly = hwdata[CFG_DLY_LSB+:16];
      end
      W_XRNG: begin
        if (hwdata[15:0] < hwdata[31:16]) begin
          {wcfg.xmx, wcfg.xmn} = hwdata;
        end
      end
      W_YRNG: begin
        wcfg.ymn = (hwdata[15:0] > lim) ? lim : hwdata[15:0];
        wcfg.ymx = (hwdata[31:16] > lim) ? lim : hwdata[31:16];
      end
      W_CMD: wcfg.x = hwdata[15:0];
      W_HOT: {wcfg.hld, wcfg.pul} = hwdata;
      W_TIM: {wcfg.bms, wcfg.pms} = hwdata;
      W_RMP: {wcfg.rdn, wcfg.rup} = hwdata;
      default: wcfg.amp = hwdata[15:0];
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NOUT; i++) begin
        cfg_r[i] <= vod_dflt(VT_OFF);
      end
    end else if (wr_r && is_out) begin
      cfg_r[oi_s] <= wcfg;
    end
  end

  a_blink_type: assert property (
    cfg_r[8].rsp == RSP_BLINK |-> cfg_r[8].typ == VT_ONOFF)
    else $error("blink response held by a non on/off output");
  a_duty_clamp: assert property (
    cfg_r[4].typ == VT_DUTY |-> cfg_r[4].ymx <= DUTY_MAX)
    else $error("duty output maximum beyond range");

  // ----------------------------------------------------------------
  // group timers
  // ----------------------------------------------------------------
  logic [NGRP-1:0] cur_grp, dph_r;
  logic [15:0] per_r [NGRP];
  logic [15:0] cnt_r [NGRP];
  logic [23:0] dh_r [NGRP];
  logic [23:0] dc_r [NGRP];

  always_comb begin
    cur_grp = '0;
    for (int i = 0; i < NOUT; i++) begin
      if (cfg_r[i].typ == VT_CUR || cfg_r[i].typ == VT_HOT) begin
        cur_grp[grp(i)] = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int g = 0; g < NGRP; g++) begin
        per_r[g] <= PER_25K;
        dh_r[g] <= DITH_RST;
      end
    end else begin
      for (int g = 0; g < NGRP; g++) begin
        if (cur_grp[g]) begin
          per_r[g] <= PER_25K;
        end else if (wr_r && is_grp && gi == 2'(g) && !a_r[2]
                     && hwdata[15:0] != 16'h0) begin
          per_r[g] <= hwdata[15:0];
        end
        if (wr_r && is_grp && gi == 2'(g) && a_r[2]
            && hwdata[23:0] != 24'h0) begin
          dh_r[g] <= hwdata[23:0];
        end
      end
    end
  end

  a_grp_force: assert property (
    $rose(cur_grp[0]) |=> per_r[0] == PER_25K)
    else $error("group 0 not forced to 25 kHz");
  a_per_lock: assert property (
    cur_grp[2] |=> per_r[2] == PER_25K)
    else $error("group 2 frequency changed while locked");

  // one counter per group keeps its outputs on one frequency
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int g = 0; g < NGRP; g++) begin
        cnt_r[g] <= 16'h0;
        dc_r[g] <= 24'h0;
        dph_r[g] <= 1'b0;
      end
    end else begin
      for (int g = 0; g < NGRP; g++) begin
        cnt_r[g] <= (cnt_r[g] + 16'h1 >= per_r[g]) ? 16'h0
                  : cnt_r[g] + 16'h1;
        if (dc_r[g] + 24'h1 >= dh_r[g]) begin
          dc_r[g] <= 24'h0;
          dph_r[g] <= !dph_r[g];
        end else begin
          dc_r[g] <= dc_r[g] + 24'h1;
        end
      end
    end
  end

  logic [15:0] mc_r;
  logic tick_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mc_r <= 16'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= mc_r == 16'(MS_CYCLES - 1);
      mc_r <= (mc_r == 16'(MS_CYCLES - 1)) ? 16'h0 : mc_r + 16'h1;
    end
  end

  // ----------------------------------------------------------------
  // digital command and response
  // ----------------------------------------------------------------
  logic [NOUT-1:0] cmd_r, cmdd_r, dig_r;
  logic [15:0] dcn_r [NOUT];
  logic [15:0] bcn_r [NOUT];
  logic [15:0] pcn_r [NOUT];

  // between the axis ends the command keeps its last state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_r <= '0;
      cmdd_r <= '0;
    end else begin
      cmdd_r <= cmd_r;
      for (int i = 0; i < NOUT; i++) begin
        if (cfg_r[i].x >= cfg_r[i].xmx) begin
          cmd_r[i] <= 1'b1;
        end else if (cfg_r[i].x <= cfg_r[i].xmn) begin
          cmd_r[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dig_r <= '0;
      for (int i = 0; i < NOUT; i++) begin
        dcn_r[i] <= 16'h0;
        bcn_r[i] <= 16'h0;
      end
    end else begin
      for (int i = 0; i < NOUT; i++) begin
        case (cfg_r[i].rsp)
          RSP_INV: dig_r[i] <= !cmd_r[i];
          RSP_LATCH: begin
            if (cmd_r[i] && !cmdd_r[i]) begin
              dig_r[i] <= !dig_r[i];
            end
          end
          RSP_BLINK: begin
            if (!cmd_r[i]) begin
              dig_r[i] <= 1'b0;
              bcn_r[i] <= 16'h0;
            end else if (!cmdd_r[i]) begin
              dig_r[i] <= 1'b1;
            end else if (tick_r) begin
              if (bcn_r[i] + 16'h1 >= cfg_r[i].bms) begin
                dig_r[i] <= !dig_r[i];
                bcn_r[i] <= 16'h0;
              end else begin
                bcn_r[i] <= bcn_r[i] + 16'h1;
              end
            end
          end
          default: begin
            // granularity of the delay is one millisecond tick
            if (cmd_r[i] == dig_r[i]) begin
              dcn_r[i] <= 16'h0;
            end else if (cfg_r[i].dly != 16'h0
                         && cmd_r[i] != cfg_r[i].edg
                         && dcn_r[i] < cfg_r[i].dly) begin
              dcn_r[i] <= dcn_r[i] + {15'h0, tick_r};
            end else begin
              dig_r[i] <= cmd_r[i];
              dcn_r[i] <= 16'h0;
            end
          end
        endcase
      end
    end
  end

  a_inv_resp: assert property (
    cfg_r[8].rsp == RSP_INV |=> dig_r[8] == !$past(cmd_r[8]))
    else $error("inverse response does not invert");
  sequence s_rise;
    cfg_r[8].rsp == RSP_LATCH && cmd_r[8] && !cmdd_r[8];
  endsequence
  a_latch_tog: assert property (
    s_rise |=> dig_r[8] != $past(dig_r[8]))
    else $error("latched output did not toggle");
  a_blink_off: assert property (
    cfg_r[8].rsp == RSP_BLINK && !cmd_r[8] |=> !dig_r[8])
    else $error("blink output on while command off");

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NOUT; i++) begin
        pcn_r[i] <= 16'h0;
      end
    end else begin
      for (int i = 0; i < NOUT; i++) begin
        if (!dig_r[i]) begin
          pcn_r[i] <= 16'h0;
        end else if (tick_r && pcn_r[i] < cfg_r[i].pms) begin
          pcn_r[i] <= pcn_r[i] + 16'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // linear map, ramp step and duty, one output per cycle
  // ----------------------------------------------------------------
  logic [3:0] sl_r;
  logic [15:0] tgt_r [NOUT];
  logic [15:0] stp_r [NOUT];
  logic [15:0] lev_r [NOUT];
  logic [15:0] dut_r [NOUT];
  vod_cfg_t sc;
  logic [15:0] span, q, y, rt, le, fs, per, sq;
  logic [16:0] sum;
  logic [31:0] dq;
  int sg;

  always_comb begin
    sc = cfg_r[sl_r];
    sg = grp(int'(sl_r));
    per = per_r[sg];
    span = (sc.ymx >= sc.ymn) ? sc.ymx - sc.ymn : sc.ymn - sc.ymx;
    q = 16'(udiv({16'h0, span} * {16'h0, sc.x - sc.xmn},
                 sc.xmx - sc.xmn));
    if (sc.x <= sc.xmn) begin
      y = sc.ymn;
    end else if (sc.x >= sc.xmx) begin
      y = sc.ymx;
    end else begin
      y = (sc.ymx >= sc.ymn) ? sc.ymn + q : sc.ymn - q;
    end
    rt = (y > lev_r[sl_r]) ? sc.rup : sc.rdn;
    // step is range over ramp time, at least one unit
    sq = 16'(udiv({16'h0, span}, rt));
    if (sq == 16'h0) begin
      sq = 16'h1;
    end
    le = lev_r[sl_r];
    fs = CUR_MAX;
    sum = 17'h0;
    case (sc.typ)
      VT_CUR: begin
        sum = dph_r[sg] ? {1'b0, le} + {1'b0, sc.amp}
            : ((le > sc.amp) ? {1'b0, le - sc.amp} : 17'h0);
        le = sum[16] ? 16'hffff : sum[15:0];
      end
      VT_HOT: begin
        le = !dig_r[sl_r] ? 16'h0
           : ((pcn_r[sl_r] < sc.pms) ? sc.pul : sc.hld);
      end
      VT_DUTY: fs = DUTY_MAX;
      VT_VOLT: fs = vsupply_mv;
      default: le = 16'h0;
    endcase
    dq = udiv({16'h0, le} * {16'h0, per}, fs);
    if (sc.typ == VT_ONOFF) begin
      dq = dig_r[sl_r] ? {16'h0, per} : 32'h0;
    end
    if (dq > {16'h0, per}) begin
      dq = {16'h0, per};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sl_r <= 4'h0;
      for (int i = 0; i < NOUT; i++) begin
        tgt_r[i] <= 16'h0;
        stp_r[i] <= 16'h0;
        dut_r[i] <= 16'h0;
      end
    end else begin
      sl_r <= (sl_r == 4'(NOUT - 1)) ? 4'h0 : sl_r + 4'h1;
      tgt_r[sl_r] <= y;
      stp_r[sl_r] <= (rt == 16'h0) ? 16'h0 : sq;
      dut_r[sl_r] <= dq[15:0];
    end
  end

  a_onoff_full: assert property (
    cfg_r[8].typ == VT_ONOFF && dig_r[8] && sl_r == 4'h8
    |=> dut_r[8] == $past(per_r[2]))
    else $error("on/off output not driven fully on");

  // ramp moves once a millisecond; zero ramp time jumps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NOUT; i++) begin
        lev_r[i] <= 16'h0;
      end
    end else begin
      for (int i = 0; i < NOUT; i++) begin
        if (stp_r[i] == 16'h0) begin
          lev_r[i] <= tgt_r[i];
        end else if (tick_r) begin
          if (tgt_r[i] > lev_r[i]) begin
            lev_r[i] <= (tgt_r[i] - lev_r[i] > stp_r[i])
                      ? lev_r[i] + stp_r[i] : tgt_r[i];
          end else begin
            lev_r[i] <= (lev_r[i] - tgt_r[i] > stp_r[i])
                      ? lev_r[i] - stp_r[i] : tgt_r[i];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // half-bridge drive
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs_on <= '0;
      ls_on <= '0;
    end else begin
      for (int i = 0; i < NOUT; i++) begin
        if (cfg_r[i].typ == VT_OFF) begin
          hs_on[i] <= 1'b0;
          ls_on[i] <= 1'b0;
        end else begin
          hs_on[i] <= cnt_r[grp(i)] < dut_r[i];
          ls_on[i] <= !(cnt_r[grp(i)] < dut_r[i]);
        end
      end
    end
  end

  a_off_drive: assert property (
    cfg_r[0].typ == VT_OFF |=> !hs_on[0] && !ls_on[0])
    else $error("disabled output still driven");
  a_bridge: assert property (
    cfg_r[8].typ != VT_OFF |=> hs_on[8] != ls_on[8])
    else $error("half-bridge legs not complementary");

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rdat = 32'h0;
    if (is_grp) begin
      rdat = a_r[2] ? {8'h0, dh_r[gi]} : {16'h0, per_r[gi]};
    end else if (is_out) begin
      case (wi)
        W_CFG: rdat = {cfg_r[oi_s].dly, 7'h0, cfg_r[oi_s].edg, 2'h0,
                       cfg_r[oi_s].rsp, 1'b0, cfg_r[oi_s].typ};
        W_XRNG: rdat = {cfg_r[oi_s].xmx, cfg_r[oi_s].xmn};
        W_YRNG: rdat = {cfg_r[oi_s].ymx, cfg_r[oi_s].ymn};
        W_CMD: rdat = {lev_r[oi_s], cfg_r[oi_s].x};
        W_HOT: rdat = {cfg_r[oi_s].hld, cfg_r[oi_s].pul};
        W_TIM: rdat = {cfg_r[oi_s].bms, cfg_r[oi_s].pms};
        W_RMP: rdat = {cfg_r[oi_s].rdn, cfg_r[oi_s].rup};
        default: rdat = {15'h0, dig_r[oi_s], cfg_r[oi_s].amp};
      endcase
    end
  end

endmodule : vod_top

`default_nettype wire

/* File: dv/vod_coil.sv */
// load model: counts high-side on time, flags shoot-through
`timescale 1ns/100ps
`default_nettype none
module vod_coil (
  input wire logic hclk,
  input wire logic clr,
  input wire logic [3:0] sel,
  input wire logic [vod_pkg::NOUT-1:0] hs_on,
  input wire logic [vod_pkg::NOUT-1:0] ls_on,
  output logic [15:0] hi_cnt,
  output logic shoot
);
  import vod_pkg::*;
  // a coil averages its drive, so on time per window is what it sees
  always_ff @(posedge hclk) begin
    hi_cnt <= clr ? 16'h0000 : hi_cnt + 16'(hs_on[sel]);
    shoot <= (clr ? 1'b0 : shoot) | (|(hs_on & ls_on));
  end
endmodule : vod_coil
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the valve output driver
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import vod_pkg::*;
  logic hclk, hresetn, hsel, hwrite, clr, shoot, hreadyout, hresp, s;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] vsupply_mv, hi_cnt;
  logic [3:0] sel;
  logic [NOUT-1:0] hs_on, ls_on;
  int fails = 0;
  int n_compared = 0;

  vod_top #(.MS_CYCLES(20)) vod_top_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .vsupply_mv(vsupply_mv),
    .hs_on(hs_on), .ls_on(ls_on));
  vod_coil vod_coil_inst (.hclk(hclk), .clr(clr), .sel(sel),
    .hs_on(hs_on), .ls_on(ls_on), .hi_cnt(hi_cnt), .shoot(shoot));

  initial begin
    hclk = 0;
    forever #25 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : chk

  // hready is looked at on the falling edge: same value the rising edge takes
  task automatic rdy;
    int n = 0;
    @(negedge hclk);
    while (hreadyout !== 1'b1 && n < 20) begin
      @(negedge hclk);
      n++;
    end
    if (n == 20) begin
      fails++;
      tally_and_finish();
    end
    rd = hrdata;
    @(posedge hclk);
  endtask : rdy

  task automatic xfer(input logic w, input logic [31:0] a, d);
    hsel <= 1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    rdy();
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
  endtask : xfer

  task automatic wr(input logic [31:0] a, d);
    xfer(1, a, d);
  endtask : wr

  task automatic rc(input string nm, input logic [31:0] a, e);
    xfer(0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rc

  function automatic logic [31:0] oa(input int i, input logic [2:0] w);
    return 32'(OUT_BASE) + 32'(i << OUT_SH) + 32'({w, 2'b00});
  endfunction : oa

  function automatic logic [31:0] cfg(input vod_typ_t t, input vod_rsp_t r,
    input logic e, input logic [15:0] d);
    return {d, 7'h00, e, 2'h0, r, 1'b0, t};
  endfunction : cfg

  // gate must reach v no sooner than lo cycles; lo == hi means never
  task automatic gate(input string nm, input int i, input logic v,
    input int lo, hi);
    int n = 0;
    @(negedge hclk);
    while (hs_on[i] !== v && n < hi) begin
      @(negedge hclk);
      n++;
    end
    chk(nm, 32'h1, 32'(n >= lo && (n < hi || lo == hi)));
    @(posedge hclk);
  endtask : gate

  // on time over one full pwm period, within two clocks of rounding
  task automatic duty(input string nm, input int i, input logic [15:0] x,
    input int per, input logic [15:0] e);
    wr(oa(i, W_CMD), {16'h0000, x});
    repeat (per + 20) @(posedge hclk);
    sel <= 4'(i);
    clr <= 1;
    @(posedge hclk);
    clr <= 0;
    repeat (per) @(posedge hclk);
    @(negedge hclk);
    chk(nm, 32'(e), (hi_cnt + 2 >= e && hi_cnt <= e + 2) ? 32'(e) : hi_cnt);
    @(posedge hclk);
  endtask : duty

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    hresetn = 0;
    hsel = 0;
    haddr = 0;
    htrans = 0;
    hwrite = 0;
    hwdata = 0;
    vsupply_mv = 16'h5dc0;
    clr = 1;
    sel = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    clr <= 0;
    chk("drive idle", 32'h0, 32'({hs_on, ls_on}));
    rc("grp0 period", 32'h0, 32'(PER_25K));
    rc("grp0 dither", 32'h4, 32'(DITH_RST));
    rc("unmapped", 32'hffc, 32'h0);
    wr(oa(9, W_CMD), 32'h03e8);
    chk("off type", 32'h0, 32'({hs_on[9], ls_on[9]}));
    $display("test reset done");
    wr(32'h10, 32'h190);
    wr(32'h20, 32'h190);
    wr(32'h0, 32'h190);
    rc("grp0 free", 32'h0, 32'h190);
    wr(oa(0, W_CFG), cfg(VT_CUR, RSP_NORM, 0, 0));
    rc("grp0 forced", 32'h0, 32'(PER_25K));
    wr(32'h0, 32'h190);
    rc("grp0 locked", 32'h0, 32'(PER_25K));
    rc("grp1 own", 32'h10, 32'h190);
    $display("test group frequency done");
    wr(oa(4, W_CFG), cfg(VT_DUTY, RSP_NORM, 0, 0));
    wr(oa(4, W_YRNG), 32'hffff0005);
    rc("y clamp", oa(4, W_YRNG), {DUTY_MAX, 16'h0005});
    wr(oa(4, W_XRNG), 32'h00640064);
    rc("x refused", oa(4, W_XRNG), {X_MAX_RST, 16'h0});
    wr(oa(4, W_CFG), cfg(VT_VOLT, RSP_NORM, 0, 0));
    rc("y reload", oa(4, W_YRNG), {VOLT_RST, 16'h0});
    duty("volt", 4, 16'h03e8, 400, 16'd200);
    wr(oa(4, W_CFG), cfg(VT_DUTY, RSP_NORM, 0, 0));
    duty("duty half", 4, 16'h01f4, 400, 16'd200);
    duty("duty full", 4, 16'h03e8, 400, 16'd400);
    duty("duty zero", 4, 16'h0000, 400, 16'd0);
    wr(oa(4, W_YRNG), 32'h000003e8);
    duty("y inverted", 4, 16'h00fa, 400, 16'd300);
    wr(oa(4, W_RMP), 32'h000a000a);
    wr(oa(4, W_CMD), 32'h03e8);
    repeat (50) @(posedge hclk);
    xfer(0, oa(4, W_CMD), 32'h0);
    chk("ramp step", 32'h1,
        32'(rd[31:16] == 16'd450 || rd[31:16] == 16'd550));
    repeat (200) @(posedge hclk);
    rc("ramp end", oa(4, W_CMD), 32'h000003e8);
    $display("test proportional done");
    wr(oa(8, W_CFG), cfg(VT_ONOFF, RSP_NORM, 0, 16'h2));
    wr(oa(8, W_CMD), 32'h03e8);
    gate("rise delayed", 8, 1, 15, 90);
    wr(oa(8, W_CMD), 32'h0);
    gate("fall prompt", 8, 0, 0, 15);
    wr(oa(8, W_CFG), cfg(VT_ONOFF, RSP_NORM, 1, 16'h2));
    wr(oa(8, W_CMD), 32'h03e8);
    gate("rise prompt", 8, 1, 0, 15);
    wr(oa(8, W_CMD), 32'h0);
    gate("fall delayed", 8, 0, 15, 90);
    wr(oa(8, W_CFG), cfg(VT_ONOFF, RSP_INV, 0, 0));
    gate("inverse idle", 8, 1, 0, 15);
    wr(oa(8, W_CMD), 32'h03e8);
    gate("inverse on", 8, 0, 0, 15);
    wr(oa(8, W_CFG), cfg(VT_ONOFF, RSP_LATCH, 0, 0));
    wr(oa(8, W_CMD), 32'h0);
    s = hs_on[8];
    wr(oa(8, W_CMD), 32'h03e8);
    gate("latch toggle", 8, ~s, 0, 15);
    wr(oa(8, W_CMD), 32'h0);
    gate("latch hold", 8, s, 40, 40);
    wr(oa(8, W_CFG), cfg(VT_ONOFF, RSP_BLINK, 0, 0));
    wr(oa(8, W_TIM), 32'h00010064);
    wr(oa(8, W_CMD), 32'h03e8);
    gate("blink on", 8, 1, 0, 50);
    gate("blink off", 8, 0, 0, 50);
    gate("blink again", 8, 1, 0, 50);
    wr(oa(8, W_CMD), 32'h0);
    gate("blink stop", 8, 0, 0, 15);
    gate("blink held", 8, 1, 60, 60);
    $display("test digital response done");
    wr(oa(8, W_CFG), cfg(VT_HOT, RSP_BLINK, 0, 0));
    rc("no hot blink", oa(8, W_CFG), cfg(VT_HOT, RSP_NORM, 0, 0));
    wr(32'h20, 32'h1f4);
    rc("grp2 locked", 32'h20, 32'(PER_25K));
    duty("pull in", 8, 16'h03e8, 800, 16'd640);
    duty("hold", 8, 16'h03e8, 800, 16'd160);
    chk("no shoot", 32'h0, 32'(shoot));
    chk("hresp okay", 32'h0, 32'(hresp));
    $display("test pull-in done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
